// [mfs_pkg.sv]
/*
  Constants, register map and types for the multiplexer frame and chop sequencer.
  Assumes an APB host with 32-bit data and a synchronous slow tick sampled on pclk.
*/
// Notes on behaviour
// - host writes a two-bit chop mode steering the amplifier swap
// - after the last state, one extra slow tick passes before the next frame
// - amplifier swap updates at the start of that extra tick
// - frame sync is high for exactly that extra tick
// - frame sync leading edge starts a live monitor readout; the engine pass restarts at its trailing edge
// - positive mode holds swap and chop clock low
// - reverse mode holds swap and chop clock high
// - first toggle mode toggles each frame and forces a last alternate frame
// - first toggle mode skips the toggle before the forced alternate frame
// - second toggle mode toggles every frame and forces nothing
// - swap high reverses the reference amplifier inputs
// - frames per accumulation interval are always even
// - battery load and sampling run in alternate frames while enabled
// - battery result goes to data word 0x0B from state 2 of each alternate frame
// - battery enable counts as zero while main supply is absent
// - engine pass restarts when state 0 begins and ends on halt
// - code start is 1024 times the page, region at most 4096 words
// - engine reads up to 1024 data words from address zero
// - data RAM access is time sliced between filter, host and engine
// - results land at fixed words 0x00 to 0x03, 0x09, 0x0A and 0x0B
// - two accumulation levels of programmed counts 2 and 6 bits wide
// - accumulation done interrupt pulses when an interval completes
// - request rising edge runs one alternate frame at the next boundary
// - states per frame range 1 to 10, always from the first slot
// - states begin on a tick edge with filter start, advance after done
package mfs_pkg;
  localparam logic [12:0] REG_CTRL = 13'h0000;
  localparam logic [12:0] REG_ACCUM = 13'h0004;
  localparam logic [12:0] REG_PAGE = 13'h0008;
  localparam logic [12:0] REG_STATUS = 13'h000C;
  localparam logic [12:0] REG_CODE = 13'h0010;
  localparam int RAM_SEL_BIT = 12;
  localparam int CTRL_ALT = 0;
  localparam int CTRL_MODE_LO = 4;
  localparam int CTRL_BME = 6;
  localparam int CTRL_DIV_LO = 8;
  localparam int ACC_PRE_LO = 0;
  localparam int ACC_SUM_LO = 8;
  localparam int STAT_DONE = 31;
  localparam logic [31:0] CTRL_RST = 32'h0000_0400;
  localparam logic [31:0] ACCUM_RST = 32'h0000_0101;
  localparam logic [7:0] PAGE_RST = 8'h00;
  localparam logic [1:0] MODE_TOG1 = 2'h0;
  localparam logic [1:0] MODE_POS = 2'h1;
  localparam logic [1:0] MODE_REV = 2'h2;
  localparam logic [1:0] MODE_TOG2 = 2'h3;
  localparam logic [9:0] ADR_AUX = 10'h009;
  localparam logic [9:0] ADR_TEMP = 10'h00A;
  localparam logic [9:0] ADR_VBAT = 10'h00B;
  localparam logic [3:0] ALT_TEMP_STATE = 4'h0;
  localparam logic [3:0] ALT_VBAT_STATE = 4'h2;
  localparam logic [3:0] DIRECT_STATES = 4'h4;
  localparam logic [18:0] CODE_LAST_OFS = 19'h0_0FFF;
  localparam int CODE_PAGE_SHIFT = 10;
  localparam logic [1:0] SLOT_FIR = 2'h0;
  localparam logic [1:0] SLOT_HOST = 2'h1;
  localparam logic [1:0] SLOT_ENG = 2'h2;
  typedef enum logic [1:0] {
    SQ_ARM = 2'b00,
    SQ_CONV = 2'b01,
    SQ_HOLD = 2'b10,
    SQ_SETTLE = 2'b11
  } mfs_seq_t;
endpackage : mfs_pkg

// [mfs_sequencer.sv]
/*
  Frame sequencer: chop control, extra settle tick, frame sync, alternate frames,
  battery gating, engine code page, shared data RAM slots and accumulation count.
  Assumes slow_tick_clock and filter/engine handshakes are synchronous to pclk.
*/
`timescale 1ns/1ps
`default_nettype none
module mfs_sequencer
  import mfs_pkg::*;
#(
  parameter int MAX_STATES = 10,
  parameter int RAM_WORDS = 1024
) (
  input wire logic pclk, // bus and sequencer clock
  input wire logic presetn, // async reset, low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [12:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic slow_tick_clock, // 32768 Hz tick, sampled
  input wire logic sys_supply_sense, // high while main supply present
  output logic filter_start, // one-cycle start of a conversion
  input wire logic filter_done, // one-cycle end of a conversion
  input wire logic [31:0] filter_result, // conversion result
  output logic [3:0] mux_state, // current multiplexer state
  output logic alt_frame_active, // current frame is alternate
  output logic batt_load_on, // battery load and scaled sample on
  output logic amp_swap, // high reverses reference amp inputs
  output logic chop_clock_out, // chop clock
  output logic frame_sync_pulse, // high for the settle tick
  output logic monitor_readout_start, // pulse: live monitor readout begins
  output logic engine_pc_restart, // pulse: engine pass restarts
  input wire logic engine_halt, // pulse: engine executed halt
  output logic engine_busy, // engine pass running
  output logic [18:0] engine_code_base, // first code word address
  output logic [18:0] engine_code_last, // last allowed code word address
  input wire logic [9:0] engine_ram_addr, // engine data word address
  output logic [31:0] engine_ram_rdata, // engine read data
  output logic accum_done_irq // pulse: accumulation interval done
);
  if (MAX_STATES < 1 || MAX_STATES > 15 || RAM_WORDS != 1024) begin : g_bad_param
    $error("mfs_sequencer: unsupported parameter value");
  end

  typedef struct packed {
    mfs_seq_t seq;
    logic tick_q;
    logic [1:0] slot;
    logic [3:0] sidx;
    logic alt_act;
    logic alt_pend;
    logic alt_req_q;
    logic [7:0] fcnt;
    logic swap;
    logic cclk;
    logic fsync;
    logic fstart;
    logic pc_rst;
    logic mon_start;
    logic eng_busy;
    logic done_irq;
    logic done_stk;
    logic batt_load;
    logic wr_pend;
    logic [9:0] wr_adr;
    logic [31:0] wr_dat;
    logic [31:0] ctrl;
    logic [31:0] accum;
    logic [7:0] page;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [31:0] eng_rdata;
    logic [18:0] code_base;
    logic [18:0] code_last;
  } mfs_st_t;

  localparam mfs_st_t ST_RST = '{seq: SQ_ARM, ctrl: CTRL_RST, accum: ACCUM_RST, page: PAGE_RST,
                                 default: '0};

  mfs_st_t st;
  mfs_st_t nx;
  logic [31:0] ram [RAM_WORDS];
  logic tick_rise;
  logic alt_rise;
  logic [1:0] mode;
  logic batt_eff;
  logic [3:0] nst;
  logic [7:0] tot;
  logic [7:0] last_f;
  logic settle_entry;
  logic reg_hit;
  logic ram_hit;
  logic host_ram_wr;
  logic [9:0] host_widx;
  logic [31:0] rd_val;

  assign host_widx = paddr[11:2];
  assign ram_hit = paddr[RAM_SEL_BIT];
  assign reg_hit = !paddr[RAM_SEL_BIT] && paddr[11:5] == 7'h00 && paddr[1:0] == 2'h0 && paddr[4:2] <= 3'h4;
  // host writes land only in the host slot
  assign host_ram_wr = psel && penable && st.pready && pwrite && ram_hit && st.slot == SLOT_HOST;

  always_comb begin
    logic [7:0] prod;
    logic [1:0] pre;
    logic [5:0] sum;
    logic [3:0] div;
    logic [9:0] fadr;
    prod = '0;
    pre = st.accum[ACC_PRE_LO +: 2];
    sum = st.accum[ACC_SUM_LO +: 6];
    div = st.ctrl[CTRL_DIV_LO +: 4];
    fadr = '0;
    nx = st;
    nx.fstart = 1'b0;
    nx.pc_rst = 1'b0;
    nx.mon_start = 1'b0;
    nx.done_irq = 1'b0;
    nx.tick_q = slow_tick_clock;
    nx.slot = st.slot + 2'h1;
    tick_rise = slow_tick_clock && !st.tick_q;
    mode = st.ctrl[CTRL_MODE_LO +: 2];
    batt_eff = st.ctrl[CTRL_BME] && sys_supply_sense;
    alt_rise = st.ctrl[CTRL_ALT] && !st.alt_req_q;
    nx.alt_req_q = st.ctrl[CTRL_ALT];
    // states per frame clamp to 1..MAX_STATES
    if (div == 4'h0) begin
      nst = 4'h1;
    end else if (32'(div) > MAX_STATES) begin
      nst = 4'(MAX_STATES);
    end else begin
      nst = div;
    end
    // interval length pre*sum frames, rounded up to even
    prod = ((pre == 2'h0) ? 8'h01 : {6'h00, pre}) * ((sum == 6'h00) ? 8'h01 : {2'h0, sum});
    tot = prod + {7'h00, prod[0]};
    last_f = tot - 8'h01;
    settle_entry = 1'b0;
    // cleared first so that a result captured in the filter slot is not lost
    if (st.wr_pend && st.slot == SLOT_FIR) begin
      nx.wr_pend = 1'b0;
    end
    if (engine_halt) begin
      nx.eng_busy = 1'b0;
    end
    if (tick_rise && (st.seq == SQ_ARM || st.seq == SQ_SETTLE)) begin
      // new frame: state 0 from first slot, engine pass restarts
      nx.seq = SQ_CONV;
      nx.sidx = 4'h0;
      nx.fstart = 1'b1;
      nx.pc_rst = 1'b1;
      nx.eng_busy = 1'b1;
      nx.alt_act = st.alt_pend || (mode == MODE_TOG1 && st.fcnt == last_f);
      nx.alt_pend = 1'b0;
    end else begin
      case (st.seq)
        SQ_CONV: begin
          if (filter_done) begin
            if (st.alt_act && st.sidx == ALT_TEMP_STATE) begin
              fadr = ADR_TEMP;
            end else if (st.alt_act && st.sidx == ALT_VBAT_STATE) begin
              fadr = ADR_VBAT;
            end else if (st.sidx < DIRECT_STATES) begin
              fadr = {6'h00, st.sidx};
            end else begin
              fadr = ADR_AUX;
            end
            nx.wr_pend = 1'b1;
            nx.wr_adr = fadr;
            nx.wr_dat = filter_result;
            nx.seq = SQ_HOLD;
          end
        end
        SQ_HOLD: begin
          if (tick_rise) begin
            if (st.sidx >= nst - 4'h1) begin
              nx.seq = SQ_SETTLE;
              nx.mon_start = 1'b1;
              settle_entry = 1'b1;
              if (st.fcnt >= last_f) begin
                nx.fcnt = 8'h00;
                nx.done_irq = 1'b1;
                nx.done_stk = 1'b1;
              end else begin
                nx.fcnt = st.fcnt + 8'h01;
              end
            end else begin
              nx.sidx = st.sidx + 4'h1;
              nx.fstart = 1'b1;
              nx.seq = SQ_CONV;
            end
          end
        end
        default: begin
        end
      endcase
    end
    if (alt_rise) begin
      nx.alt_pend = 1'b1;
    end
    // swap: held in fixed modes, updated at settle entry when toggling
    if (mode == MODE_POS) begin
      nx.swap = 1'b0;
    end else if (mode == MODE_REV) begin
      nx.swap = 1'b1;
    end else if (settle_entry && (mode == MODE_TOG2 || st.fcnt != last_f - 8'h01)) begin
      nx.swap = !st.swap;
    end
    nx.cclk = nx.swap;
    nx.fsync = nx.seq == SQ_SETTLE;
    nx.batt_load = batt_eff && nx.alt_act && nx.seq != SQ_ARM;
    if (st.slot == SLOT_ENG) begin
      nx.eng_rdata = ram[engine_ram_addr];
    end
    nx.code_base = {1'b0, st.page, 10'h000};
    nx.code_last = nx.code_base + CODE_LAST_OFS;
    case (paddr)
      REG_CTRL: rd_val = st.ctrl;
      REG_ACCUM: rd_val = st.accum;
      REG_PAGE: rd_val = {24'h00_0000, st.page};
      REG_STATUS: rd_val = {st.done_stk, 3'h0, st.eng_busy, st.alt_pend, st.alt_act, st.swap, batt_eff,
                            3'h0, st.seq, st.sidx, 6'h00, st.fcnt};
      REG_CODE: rd_val = {13'h0000, st.code_base};
      default: rd_val = 32'h0000_0000;
    endcase
    if (psel && penable) begin
      if (!st.pready) begin
        if (!ram_hit) begin
          nx.pready = 1'b1;
          nx.pslverr = !reg_hit;
          nx.prdata = rd_val;
        end else if (st.slot == SLOT_FIR) begin
          nx.pready = 1'b1;
          nx.pslverr = 1'b0;
          nx.prdata = ram[host_widx];
        end
      end else begin
        nx.pready = 1'b0;
        nx.pslverr = 1'b0;
        if (pwrite && reg_hit) begin
          case (paddr)
            REG_CTRL: nx.ctrl = pwdata;
            REG_ACCUM: nx.accum = pwdata & 32'h0000_3F03;
            REG_PAGE: nx.page = pwdata[7:0];
            default: begin
            end
          endcase
          if (paddr == REG_STATUS && pwdata[STAT_DONE] && !nx.done_irq) begin
            nx.done_stk = 1'b0;
          end
        end
      end
    end else begin
      nx.pready = 1'b0;
      nx.pslverr = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= ST_RST;
    end else begin
      st <= nx;
    end
  end

  always_ff @(posedge pclk) begin
    if (st.wr_pend && st.slot == SLOT_FIR) begin
      ram[st.wr_adr] <= st.wr_dat;
    end else if (host_ram_wr) begin
      ram[host_widx] <= pwdata;
    end
  end

  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign filter_start = st.fstart;
  assign mux_state = st.sidx;
  assign alt_frame_active = st.alt_act;
  assign batt_load_on = st.batt_load;
  assign amp_swap = st.swap;
  assign chop_clock_out = st.cclk;
  assign frame_sync_pulse = st.fsync;
  assign monitor_readout_start = st.mon_start;
  assign engine_pc_restart = st.pc_rst;
  assign engine_busy = st.eng_busy;
  assign engine_code_base = st.code_base;
  assign engine_code_last = st.code_last;
  assign engine_ram_rdata = st.eng_rdata;
  assign accum_done_irq = st.done_irq;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence settle_open;
    $rose(frame_sync_pulse);
  endsequence
  sequence settle_close;
    $fell(frame_sync_pulse);
  endsequence

  sync_launch_a: assert property (settle_open |-> monitor_readout_start && !filter_start)
    else $error("frame sync rise without monitor readout start");
  sync_end_a: assert property (settle_close |-> filter_start && engine_pc_restart && mux_state == 4'h0)
    else $error("frame sync fall not at state 0 start");
  settle_tick_a: assert property (st.seq == SQ_SETTLE && tick_rise |=> settle_close)
    else $error("settle tick did not end on next tick edge");
  pos_hold_a: assert property (mode == MODE_POS [*2] |-> !amp_swap && !chop_clock_out)
    else $error("positive mode swap not low");
  rev_hold_a: assert property (mode == MODE_REV [*2] |-> amp_swap && chop_clock_out)
    else $error("reverse mode swap not high");
  tog2_flip_a: assert property (settle_open ##0 $past(mode) == MODE_TOG2 |-> amp_swap != $past(amp_swap))
    else $error("second toggle mode missed a toggle");
  tog1_skip_a: assert property (settle_open ##0 $past(mode) == MODE_TOG1 && st.fcnt == last_f
                                |-> amp_swap == $past(amp_swap))
    else $error("first toggle mode toggled before forced alternate");
  batt_gate_a: assert property (!sys_supply_sense |=> !batt_load_on)
    else $error("battery load on without main supply");
  even_total_a: assert property (accum_done_irq |-> $past(st.fcnt[0]) == 1'b1)
    else $error("odd frame count per interval");
  accum_done_a: assert property (accum_done_irq |-> st.fcnt == 8'h00 && frame_sync_pulse)
    else $error("accumulation done outside interval end");
endmodule : mfs_sequencer
`default_nettype wire

// [mfs_far_model.sv]
/*
  Far-side model: the filter and the compute engine facing the sequencer.
  Assumes handshakes synchronous to pclk; slow makes the filter answer late.
*/
`timescale 1ns/1ps
`default_nettype none
module mfs_far_model (
  input wire logic pclk, // clock
  input wire logic presetn, // async reset, low
  input wire logic slow, // late filter answers
  input wire logic filter_start, // conversion start
  input wire logic [3:0] mux_state, // current state
  input wire logic alt_frame_active, // alternate frame
  input wire logic engine_pc_restart, // pass start
  output logic filter_done, // conversion done
  output logic [31:0] filter_result, // result
  output logic engine_halt // pass end
);
  int fd;
  int hd;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fd <= -1;
      hd <= -1;
      filter_done <= 1'b0;
      engine_halt <= 1'b0;
      filter_result <= 32'h0000_0000;
    end else begin
      filter_done <= 1'b0;
      engine_halt <= 1'b0;
      // result not valid: keep it moving so nothing relies on a stale value
      filter_result <= ~filter_result;
      fd <= (fd > 0) ? fd - 1 : -1;
      hd <= (hd > 0) ? hd - 1 : -1;
      if (filter_start) begin
        fd <= slow ? 55 : 3;
      end
      if (fd == 0) begin
        filter_done <= 1'b1;
        filter_result <= {20'hF_1F00, 3'h0, alt_frame_active, 4'h0, mux_state};
      end
      if (engine_pc_restart) begin
        hd <= 10;
      end
      if (hd == 0) begin
        engine_halt <= 1'b1;
      end
    end
  end
endmodule : mfs_far_model
`default_nettype wire

// [mux_frame_chop_sequencer_bench.sv]
/*
  Self-checking bench for the frame and chop sequencer, with a fast slow tick.
  Assumes mfs_pkg, mfs_sequencer and mfs_far_model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module mux_frame_chop_sequencer_bench;
  import mfs_pkg::*;
  localparam int TICK = 20; // half tick period in pclk cycles
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [12:0] paddr = 13'h0000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, filter_result, engine_ram_rdata, q, d;
  logic slow_tick_clock = 0, sys_supply_sense = 1, slow = 0, batt_measure_en = 0, e, rise;
  logic filter_start, filter_done, alt_frame_active, batt_load_on, amp_swap, chop_clock_out;
  logic frame_sync_pulse, monitor_readout_start, engine_pc_restart, engine_halt, engine_busy;
  logic accum_done_irq, mode_ok = 0, fs_q = 0, sw_q = 0, alt_q = 0, sw_last = 0, alt_sw = 0;
  logic [3:0] mux_state, mx = 0;
  logic [18:0] engine_code_base, engine_code_last;
  logic [9:0] engine_ram_addr = 10'h000, a;
  logic [7:0] p;
  logic [1:0] cur_mode = MODE_POS;
  int errors = 0, n_compared = 0, seed = 47094, cyc = 0;
  int n_fs = 0, n_alt = 0, n_irq = 0, n_batt = 0, fs_len = 0, alt_fs = 0, irq_fs = 0, b0;

  mfs_sequencer i_mfs_sequencer (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .slow_tick_clock, .sys_supply_sense, .filter_start, .filter_done,
    .filter_result, .mux_state, .alt_frame_active, .batt_load_on, .amp_swap, .chop_clock_out,
    .frame_sync_pulse, .monitor_readout_start, .engine_pc_restart, .engine_halt, .engine_busy,
    .engine_code_base, .engine_code_last, .engine_ram_addr, .engine_ram_rdata, .accum_done_irq);
  mfs_far_model i_mfs_far_model (.pclk, .presetn, .slow, .filter_start, .mux_state,
    .alt_frame_active, .engine_pc_restart, .filter_done, .filter_result, .engine_halt);

  always #4 pclk = ~pclk;
  always begin
    repeat (TICK) @(posedge pclk);
    slow_tick_clock <= ~slow_tick_clock;
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task give_verdict();
    $display("compared=%0d errors=%0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 60000) begin
      chk(cyc, 0);
      give_verdict();
    end
  end

  // one APB transfer, entered just after a rising edge
  task apb(input logic w, input logic [12:0] ad, input logic [31:0] wd);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) chk(k, 0);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task rd(input logic [12:0] ad, input logic [31:0] exp);
    apb(1'b0, ad, 32'h0000_0000);
    chk(q, exp);
  endtask : rd

  task set_ctrl(input logic [31:0] v);
    apb(1'b1, REG_CTRL, v);
    rd(REG_CTRL, v);
  endtask : set_ctrl

  function automatic logic [31:0] ctrl(input logic [1:0] m, input logic [3:0] n, input logic al);
    ctrl = 32'h0000_0000;
    ctrl[CTRL_DIV_LO +: 4] = n;
    ctrl[CTRL_MODE_LO +: 2] = m;
    ctrl[CTRL_BME] = batt_measure_en;
    ctrl[CTRL_ALT] = al;
  endfunction : ctrl

  function automatic logic [31:0] res(input logic al, input logic [3:0] s);
    res = {20'hF_1F00, 3'h0, al, 4'h0, s};
  endfunction : res

  task wait_fs(input int n);
    int t;
    int k;
    t = n_fs + n;
    k = 0;
    while (n_fs < t && k < 20000) begin
      @(posedge pclk);
      k++;
    end
    if (n_fs < t) chk(n_fs, t);
  endtask : wait_fs

  task go(input logic [1:0] m, input logic [3:0] n);
    mode_ok = 0;
    cur_mode = m;
    set_ctrl(ctrl(m, n, 1'b0));
    wait_fs(2);
    mode_ok = 1;
    n_alt = 0;
    n_irq = 0;
    mx = 0;
  endtask : go

  always @(negedge pclk) begin
    if (presetn) begin
      rise = frame_sync_pulse && !fs_q;
      chk(chop_clock_out, amp_swap);
      if (rise) begin
        n_fs++;
        chk(monitor_readout_start, 1'b1);
        chk(engine_busy, 1'b0);
        if (mode_ok && cur_mode == MODE_TOG2) chk(amp_swap, !sw_last);
        sw_last = amp_swap;
      end else if (mode_ok) chk(amp_swap, sw_q);
      if (!frame_sync_pulse && fs_q) begin
        chk(fs_len, 2 * TICK);
        chk({engine_pc_restart, filter_start, engine_busy, mux_state}, 7'h70);
      end
      fs_len = frame_sync_pulse ? fs_len + 1 : 0;
      if (mode_ok && cur_mode inside {MODE_POS, MODE_REV}) chk(amp_swap, cur_mode == MODE_REV);
      if (alt_frame_active && !alt_q) begin
        n_alt++;
        if (cur_mode == MODE_TOG1 && n_alt > 1) begin
          chk(amp_swap, !alt_sw);
          chk(n_fs - alt_fs, 4);
        end
        alt_sw = amp_swap;
        alt_fs = n_fs;
      end
      if (accum_done_irq) begin
        n_irq++;
        if (cur_mode == MODE_TOG1 && n_irq > 1) chk(n_fs - irq_fs, 4);
        irq_fs = n_fs;
      end
      if (batt_load_on) begin
        n_batt++;
        chk(batt_measure_en & sys_supply_sense & (alt_frame_active | alt_q), 1'b1);
      end
      if (mux_state > mx) mx = mux_state;
      fs_q = frame_sync_pulse;
      sw_q = amp_swap;
      alt_q = alt_frame_active;
    end
  end

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(REG_CTRL, CTRL_RST);
    rd(REG_ACCUM, ACCUM_RST);
    rd(REG_PAGE, {24'h00_0000, PAGE_RST});
    rd(13'h0040, 32'h0000_0000);
    chk(e, 1'b1);
    $display("test reset values done");
    go(MODE_POS, 4'h1);
    wait_fs(2);
    go(MODE_REV, 4'h1);
    wait_fs(2);
    $display("test fixed modes done");
    apb(1'b1, REG_ACCUM, 32'h0000_0103); // first count 3 rounds up to 4 frames
    go(MODE_TOG1, 4'h1);
    wait_fs(13);
    chk(n_alt >= 3 && n_irq >= 3, 1'b1);
    apb(1'b0, REG_STATUS, 32'h0000_0000);
    chk(q[STAT_DONE], 1'b1);
    apb(1'b1, REG_STATUS, 32'h8000_0000);
    apb(1'b0, REG_STATUS, 32'h0000_0000);
    chk(q[STAT_DONE], 1'b0);
    slow <= 1'b1;
    go(MODE_TOG2, 4'h1);
    wait_fs(5);
    chk(n_alt, 0);
    slow <= 1'b0;
    $display("test toggle modes done");
    batt_measure_en = 1;
    go(MODE_POS, 4'h4);
    set_ctrl(ctrl(MODE_POS, 4'h4, 1'b1));
    wait_fs(3);
    chk(n_alt, 1);
    chk(n_batt > 0, 1'b1);
    sys_supply_sense <= 1'b0;
    b0 = n_batt;
    set_ctrl(ctrl(MODE_POS, 4'h4, 1'b0));
    set_ctrl(ctrl(MODE_POS, 4'h4, 1'b1));
    wait_fs(3);
    chk(n_batt, b0);
    chk(n_alt, 2);
    chk(mx, 3);
    for (int i = 0; i < 4; i++) rd(13'h1000 + 13'(4 * i), res(1'b0, 4'(i)));
    rd(13'h1028, res(1'b1, ALT_TEMP_STATE));
    rd(13'h102C, res(1'b1, ALT_VBAT_STATE));
    sys_supply_sense <= 1'b1;
    go(MODE_POS, 4'hF);
    wait_fs(1);
    chk(mx, 9);
    rd(13'h1024, res(1'b0, 4'h9));
    $display("test alternate frames done");
    for (int k = 0; k < 6; k++) begin
      p = 8'($random(seed));
      apb(1'b1, REG_PAGE, {24'h00_0000, p});
      repeat (2) @(posedge pclk);
      chk(engine_code_base, {p, 10'h000});
      chk(engine_code_last, {p, 10'h000} + 19'h0_0FFF);
      rd(REG_CODE, {13'h0000, 1'b0, p, 10'h000});
      d = $random(seed);
      a = (k == 0) ? 10'h3FF : {1'b1, 9'($random(seed))};
      apb(1'b1, 13'h1000 | {1'b0, a, 2'b00}, d);
      rd(13'h1000 | {1'b0, a, 2'b00}, d);
      engine_ram_addr <= a;
      repeat (8) @(posedge pclk);
      chk(engine_ram_rdata, d);
    end
    $display("test page and ram done");
    give_verdict();
  end
endmodule : mux_frame_chop_sequencer_bench
`default_nettype wire
